// >>> pkg/acsq_pkg.sv
// Register map, field layout, states and timing of the conversion sequencer
package acsq_pkg;

	localparam int unsigned NCH = 4;
	localparam int unsigned RES = 10;

	// Byte addresses of the word registers
	localparam logic [7:0] OFS_CSR  = 8'h00;
	localparam logic [7:0] OFS_ETC  = 8'h04;
	localparam logic [7:0] OFS_IEG  = 8'h08;
	localparam logic [7:0] OFS_DAT0 = 8'h10;

	// converter_control_status fields
	localparam int unsigned CSR_FLAG  = 7;
	localparam int unsigned CSR_IEN   = 6;
	localparam int unsigned CSR_START = 5;
	localparam int unsigned CSR_SCAN  = 4;
	localparam int unsigned CSR_SPD   = 3;
	localparam int unsigned CSR_CH_HI = 2;
	localparam int unsigned CSR_CH_LO = 0;

	// external_trigger_control fields
	localparam int unsigned ETC_TRIGGER_ENABLE  = 7;
	localparam int unsigned ETC_RSV0  = 0;
	localparam logic [5:0]  ETC_ONES  = 6'h3F;

	// interrupt_edge_select_reg field
	localparam int unsigned IEG_EDGE  = 5;

	localparam logic [RES-1:0] SAR_MID = 10'h200;
	localparam logic [1:0]     HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0]     HSIZE_WORD    = 3'h2;

	// Times in converter states; one state is one hclk cycle
	localparam int unsigned STATE_CYC = 1;
	localparam int unsigned T_DLY_MIN_S = 6;
	localparam int unsigned T_DLY_MIN_F = 4;
	localparam int unsigned T_RPT_S = 3;
	localparam int unsigned T_RPT_F = 1;
	localparam int unsigned SAMPLING_TIME_S = 31;
	localparam int unsigned SAMPLING_TIME_F = 15;
	localparam int unsigned T_CNV_S = 94;
	localparam int unsigned T_CNV_F = 50;
	localparam int unsigned T_BIT_S = 9;
	localparam int unsigned T_BIT_F = 5;

	localparam logic [7:0] CYC_DLY_MIN_S = 8'(T_DLY_MIN_S * STATE_CYC);
	localparam logic [7:0] CYC_DLY_MIN_F = 8'(T_DLY_MIN_F * STATE_CYC);
	localparam logic [7:0] CYC_RPT_S = 8'(T_RPT_S * STATE_CYC);
	localparam logic [7:0] CYC_RPT_F = 8'(T_RPT_F * STATE_CYC);
	localparam logic [7:0] CYC_SPL_S = 8'(SAMPLING_TIME_S * STATE_CYC);
	localparam logic [7:0] CYC_SPL_F = 8'(SAMPLING_TIME_F * STATE_CYC);
	localparam logic [7:0] CYC_CNV_S = 8'(T_CNV_S * STATE_CYC);
	localparam logic [7:0] CYC_CNV_F = 8'(T_CNV_F * STATE_CYC);
	localparam logic [3:0] CYC_BIT_S = 4'(T_BIT_S * STATE_CYC);
	localparam logic [3:0] CYC_BIT_F = 4'(T_BIT_F * STATE_CYC);

	typedef enum logic [1:0]
	{
		ST_IDLE   = 2'h0,
		ST_DELAY  = 2'h1,
		ST_SAMPLE = 2'h3,
		ST_CONV   = 2'h2
	} acsq_state_e;

	typedef enum logic [2:0]
	{
		SEL_NONE = 3'h0,
		SEL_CSR  = 3'h1,
		SEL_ETC  = 3'h2,
		SEL_IEG  = 3'h3,
		SEL_DAT  = 3'h4
	} acsq_sel_e;

endpackage

// >>> logic/acsq_sync.sv
// Three-stage pin synchroniser; the level moves once stages two and three agree
`timescale 1ns/1ps
module acsq_sync
	import acsq_pkg::*;
#(
	parameter logic RST_VAL = 1'b1
)
(
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic pin_in,
	output logic      level_out
);

	logic [2:0] sh_r;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			sh_r <= {3{RST_VAL}};
		else
			sh_r <= {sh_r[1:0], pin_in};
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			level_out <= RST_VAL;
		else if (sh_r[1] == sh_r[2])
			level_out <= sh_r[2];
	end

endmodule

// >>> logic/acsq_sar.sv
// Successive-approximation register: one bit decided per bit_en pulse
`timescale 1ns/1ps
module acsq_sar
	import acsq_pkg::*;
(
	input  wire logic           hclk,
	input  wire logic           hresetn,
	input  wire logic           start,
	input  wire logic           bit_en,
	input  wire logic           cmp_above,
	output logic [RES-1:0]      code
);

	logic [3:0] idx_r;

	// Trial bit stays when the input is at or above the DAC level
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			code  <= '0;
			idx_r <= '0;
		end
		else if (start)
		begin
			code  <= SAR_MID;
			idx_r <= 4'(RES - 1);
		end
		else if (bit_en)
		begin
			if (!cmp_above)
				code[idx_r] <= 1'b0;
			if (idx_r != 4'h0)
			begin
				code[idx_r - 4'h1] <= 1'b1;
				idx_r              <= idx_r - 4'h1;
			end
		end
	end

endmodule

// >>> logic/acsq_top.sv
// Conversion sequencer of a 10-bit SAR converter with AHB-Lite registers
//
// Functional notes
// - Trigger enable bit 7 set: trigger pin edge starts conversion; clear: ignored.
// - Active trigger edge comes from the edge-select register, not trigger control.
// - Trigger control bits 6..1 read as ones and ignore writes.
// - Results by 10-bit successive approximation; single and scan modes.
// - Single mode: one conversion of the selected channel per start.
// - Single mode: result goes to that channel's data register.
// - Single mode: completion sets end flag; interrupt if enabled.
// - Single mode: start holds during conversion, self-clears, then idle.
// - Scan mode: convert the group in order from the first channel.
// - Scan mode: each result stored in its channel register before moving.
// - Scan mode: group end sets flag, interrupt if enabled, restarts group.
// - Scan mode: start never self-clears; repeat until software clears.
// - Start delay, then sampling, then conversion, all within total time.
// - First conversion: delay 6-9/4-5, sampling 31/15, total 131-134/69-70.
// - Later scan conversions take fixed 128 or 66 states.
// - Enabled trigger edge sets start; then behaves as software start.
// - End flag clears only on writing 0 after reading it as 1.
// - Mode bit: 0 single, 1 scan.
//
// The AHB-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module acsq_top
	import acsq_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        conversion_trigger_pin_n,
	input  wire logic        cmp_above,
	output logic [RES-1:0]   dac_code,
	output logic             sample_hold,
	output logic [1:0]       mux_channel,
	output logic             conversion_end_irq
);

	function automatic acsq_sel_e reg_sel(input logic [7:0] a);
		if (a == OFS_CSR)
			return SEL_CSR;
		else if (a == OFS_ETC)
			return SEL_ETC;
		else if (a == OFS_IEG)
			return SEL_IEG;
		else if (a[7:4] == OFS_DAT0[7:4] && a[1:0] == 2'h0)
			return SEL_DAT;
		else
			return SEL_NONE;
	endfunction

	// Bus data phase
	logic             dp_wr_r;
	logic             dp_rd_r;
	logic [7:0]       dp_addr_r;
	logic             rd_hold_r;
	logic             addr_ok;
	logic             wr_csr;
	logic             wr_etc;
	logic             wr_ieg;
	logic             rd_load;
	logic [31:0]      rd_val;

	// Register fields
	logic             flag_r;
	logic             seen_r;
	logic             ien_r;
	logic             start_r;
	logic             scan_r;
	logic             spd_r;
	logic [2:0]       chsel_r;
	logic             trigger_enable_r;
	logic             etc_b0_r;
	logic             edge_sel_r;
	logic [RES-1:0]   dat_r [NCH];

	// Sequencer
	acsq_state_e      state_r;
	logic [7:0]       cnt_r;
	logic [3:0]       divc_r;
	logic [1:0]       phase_r;
	logic [1:0]       cur_ch_r;
	logic [7:0]       first_dly;
	logic [7:0]       rpt_dly;
	logic [7:0]       spl_len;
	logic [7:0]       cnv_len;
	logic [3:0]       bit_len;
	logic             conv_end;
	logic             group_end;
	logic             sar_start;
	logic             bit_en;
	logic             flag_set;
	logic             flag_clr;

	// Trigger
	logic             trig_lvl;
	logic             trig_d_r;
	logic             trig_evt;

	assign addr_ok = hsel && hready && htrans == HTRANS_NONSEQ
		&& hsize == HSIZE_WORD;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dp_wr_r   <= 1'b0;
			dp_rd_r   <= 1'b0;
			dp_addr_r <= '0;
		end
		else if (hready)
		begin
			dp_wr_r   <= addr_ok && hwrite;
			dp_rd_r   <= addr_ok && !hwrite;
			dp_addr_r <= haddr[7:0];
		end
	end

	// One wait state on reads so a write just before has landed
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			rd_hold_r <= 1'b0;
		else
			rd_hold_r <= dp_rd_r && !rd_hold_r;
	end

	assign rd_load   = dp_rd_r && !rd_hold_r;
	assign hreadyout = !rd_load;
	assign hresp     = 1'b0;

	assign wr_csr = dp_wr_r && reg_sel(dp_addr_r) == SEL_CSR;
	assign wr_etc = dp_wr_r && reg_sel(dp_addr_r) == SEL_ETC;
	assign wr_ieg = dp_wr_r && reg_sel(dp_addr_r) == SEL_IEG;

	always_comb
	begin
		rd_val = '0;
		unique case (reg_sel(dp_addr_r))
			SEL_CSR:
				rd_val[7:0] = {flag_r, ien_r, start_r, scan_r, spd_r, chsel_r};
			SEL_ETC:
				rd_val[7:0] = {trigger_enable_r, ETC_ONES, etc_b0_r};
			SEL_IEG:
				rd_val[IEG_EDGE] = edge_sel_r;
			SEL_DAT:
				rd_val[RES-1:0] = dat_r[dp_addr_r[3:2]];
			SEL_NONE:
				rd_val = '0;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= '0;
		else if (rd_load)
			hrdata <= rd_val;
	end

	// Plain control fields
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ien_r   <= 1'b0;
			scan_r  <= 1'b0;
			spd_r   <= 1'b0;
			chsel_r <= '0;
		end
		else if (wr_csr)
		begin
			ien_r   <= hwdata[CSR_IEN];
			scan_r  <= hwdata[CSR_SCAN];
			spd_r   <= hwdata[CSR_SPD];
			chsel_r <= hwdata[CSR_CH_HI:CSR_CH_LO];
		end
	end

	// Bits 6..1 have no storage, so writes there vanish
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			trigger_enable_r   <= 1'b0;
			etc_b0_r <= 1'b0;
		end
		else if (wr_etc)
		begin
			trigger_enable_r   <= hwdata[ETC_TRIGGER_ENABLE];
			etc_b0_r <= hwdata[ETC_RSV0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			edge_sel_r <= 1'b0;
		else if (wr_ieg)
			edge_sel_r <= hwdata[IEG_EDGE];
	end

	// External trigger
	acsq_sync #(
		.RST_VAL   (1'b1)
	) u_trig_sync (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.pin_in    (conversion_trigger_pin_n),
		.level_out (trig_lvl)
	);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			trig_d_r <= 1'b1;
		else
			trig_d_r <= trig_lvl;
	end

	// Edge select 0 is the falling edge, 1 the rising edge
	assign trig_evt = trigger_enable_r && (edge_sel_r ? (!trig_d_r && trig_lvl)
		: (trig_d_r && !trig_lvl));

	// Start bit: a set from software or trigger wins over the self-clear
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			start_r <= 1'b0;
		else if (trig_evt)
			start_r <= 1'b1;
		else if (wr_csr)
			start_r <= hwdata[CSR_START];
		else if (conv_end && !scan_r)
			start_r <= 1'b0;
	end

	// End flag with read-then-write-zero clearing
	assign flag_set = conv_end && group_end;
	assign flag_clr = wr_csr && !hwdata[CSR_FLAG] && seen_r;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			flag_r <= 1'b0;
		else if (flag_set)
			flag_r <= 1'b1;
		else if (flag_clr)
			flag_r <= 1'b0;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			seen_r <= 1'b0;
		else if (flag_set || flag_clr)
			seen_r <= 1'b0;
		else if (rd_load && reg_sel(dp_addr_r) == SEL_CSR && flag_r)
			seen_r <= 1'b1;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			conversion_end_irq <= 1'b0;
		else
			conversion_end_irq <= flag_r && ien_r;
	end

	// Phase of the write against a free prescaler sets the start delay
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			phase_r <= '0;
		else
			phase_r <= phase_r + 2'h1;
	end

	always_comb
	begin
		if (spd_r)
		begin
			first_dly = CYC_DLY_MIN_F + {7'h0, phase_r[0]};
			rpt_dly   = CYC_RPT_F;
			spl_len   = CYC_SPL_F;
			cnv_len   = CYC_CNV_F;
			bit_len   = CYC_BIT_F;
		end
		else
		begin
			first_dly = CYC_DLY_MIN_S + {6'h0, phase_r};
			rpt_dly   = CYC_RPT_S;
			spl_len   = CYC_SPL_S;
			cnv_len   = CYC_CNV_S;
			bit_len   = CYC_BIT_S;
		end
	end

	assign conv_end  = state_r == ST_CONV && cnt_r == 8'h0;
	assign sar_start = state_r == ST_SAMPLE && cnt_r == 8'h0;
	assign bit_en    = state_r == ST_CONV && divc_r == bit_len - 4'h1;
	assign group_end = !scan_r || cur_ch_r == chsel_r[1:0];

	// Idle cycle counts as the first delay state
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_r <= ST_IDLE;
			cnt_r   <= '0;
		end
		else if (!start_r)
		begin
			state_r <= ST_IDLE;
			cnt_r   <= '0;
		end
		else
		begin
			unique case (state_r)
				ST_IDLE:
				begin
					state_r <= ST_DELAY;
					cnt_r   <= first_dly - 8'h2;
				end
				ST_DELAY:
				begin
					if (cnt_r == 8'h0)
					begin
						state_r <= ST_SAMPLE;
						cnt_r   <= spl_len - 8'h1;
					end
					else
						cnt_r <= cnt_r - 8'h1;
				end
				ST_SAMPLE:
				begin
					if (cnt_r == 8'h0)
					begin
						state_r <= ST_CONV;
						cnt_r   <= cnv_len - 8'h1;
					end
					else
						cnt_r <= cnt_r - 8'h1;
				end
				ST_CONV:
				begin
					if (cnt_r != 8'h0)
						cnt_r <= cnt_r - 8'h1;
					else if (scan_r)
					begin
						state_r <= ST_DELAY;
						cnt_r   <= rpt_dly - 8'h1;
					end
					else
						state_r <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			sample_hold <= 1'b0;
		else
			sample_hold <= start_r && (state_r == ST_SAMPLE && cnt_r != 8'h0
				|| state_r == ST_DELAY && cnt_r == 8'h0);
	end

	// Bit-rate enable divider; first decision lands bit_len - 2 into CONV
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			divc_r <= '0;
		else if (state_r != ST_CONV)
			divc_r <= 4'h1;
		else if (bit_en)
			divc_r <= '0;
		else
			divc_r <= divc_r + 4'h1;
	end

	acsq_sar u_sar (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.start     (sar_start),
		.bit_en    (bit_en),
		.cmp_above (cmp_above),
		.code      (dac_code)
	);

	// Channel walk; the group always begins at the first input
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			cur_ch_r <= '0;
		else if (state_r == ST_IDLE)
			cur_ch_r <= scan_r ? 2'h0 : chsel_r[1:0];
		else if (conv_end && scan_r)
			cur_ch_r <= group_end ? 2'h0 : cur_ch_r + 2'h1;
	end

	assign mux_channel = cur_ch_r;

	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++)
		begin : g_dat
			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
					dat_r[gi] <= '0;
				else if (conv_end && cur_ch_r == 2'(gi))
					dat_r[gi] <= dac_code;
			end
		end
	endgenerate

endmodule

// >>> verif/acsq_assertions.sv
// Bus handshake and conversion timing checker for the sequencer top
`timescale 1ns/1ps
module acsq_chk
	import acsq_pkg::*;
(
	input wire logic           hclk,
	input wire logic           hresetn,
	input wire logic           hsel,
	input wire logic [1:0]     htrans,
	input wire logic           hwrite,
	input wire logic [2:0]     hsize,
	input wire logic           hready,
	input wire logic           hreadyout,
	input wire logic           hresp,
	input wire logic [31:0]    hrdata,
	input wire logic [RES-1:0] dac_code,
	input wire logic           sample_hold,
	input wire logic [1:0]     mux_channel,
	input wire logic           conversion_end_irq
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	logic       go;
	logic       rd_dp_r;
	logic [7:0] hi_cnt_r;

	assign go = hsel && hready && htrans == HTRANS_NONSEQ
		&& hsize == HSIZE_WORD;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			rd_dp_r <= 1'b0;
		else if (hready)
			rd_dp_r <= go && !hwrite;
	end

	// Saturates so an endless level cannot wrap into a legal count
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hi_cnt_r <= 8'h00;
		else if (!sample_hold)
			hi_cnt_r <= 8'h00;
		else if (hi_cnt_r != 8'hFF)
			hi_cnt_r <= hi_cnt_r + 8'h01;
	end

	property p_resp;
		hresp == 1'b0;
	endproperty
	a_resp: assert property (p_resp)
		else $error("hresp not OKAY");

	property p_rdwait;
		go && !hwrite |=> !hreadyout ##1 hreadyout;
	endproperty
	a_rdwait: assert property (p_rdwait)
		else $error("read data phase not one wait state");

	property p_wr;
		go && hwrite |=> hreadyout;
	endproperty
	a_wr: assert property (p_wr)
		else $error("write data phase stalled");

	property p_hrd;
		$changed(hrdata) |-> $past(rd_dp_r && !hreadyout);
	endproperty
	a_hrd: assert property (p_hrd)
		else $error("hrdata changed outside a read");

	property p_spl;
		$fell(sample_hold) |-> hi_cnt_r == 8'h1F || hi_cnt_r == 8'h0F;
	endproperty
	a_spl: assert property (p_spl)
		else $error("sampling length wrong");

	property p_mid;
		$fell(sample_hold) |-> ##[0:2] dac_code == SAR_MID;
	endproperty
	a_mid: assert property (p_mid)
		else $error("trial code does not start at midscale");

	property p_mux;
		$fell(sample_hold) |-> $stable(mux_channel) [*8];
	endproperty
	a_mux: assert property (p_mux)
		else $error("channel moved during conversion");

	property p_dac;
		$rose(sample_hold) |-> ##2 $stable(dac_code) [*8];
	endproperty
	a_dac: assert property (p_dac)
		else $error("trial code moved while sampling");

	c_fast: cover property ($fell(sample_hold) && hi_cnt_r == 8'h0F);
	c_slow: cover property ($fell(sample_hold) && hi_cnt_r == 8'h1F);
	c_irq: cover property ($rose(conversion_end_irq));
endmodule

bind acsq_top acsq_chk i_acsq_chk (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.hrdata(hrdata), .dac_code(dac_code), .sample_hold(sample_hold),
	.mux_channel(mux_channel), .conversion_end_irq(conversion_end_irq));

// >>> verif/acsq_analog_model.sv
// Analog input model: fixed level per channel, comparator output
`timescale 1ns/1ps
module acsq_analog_model
	import acsq_pkg::*;
(
	input  wire logic [RES-1:0] dac_code,
	input  wire logic [1:0]     mux_channel,
	input  wire logic           alt,
	output logic                cmp_above
);
	logic [RES-1:0] level;

	// Second level set is the inverse, so rewritten results show
	assign level = {mux_channel, 8'hA5} ^ {RES{alt}};
	assign cmp_above = level >= dac_code;
endmodule

// >>> verif/tb.sv
// Register-level testbench of the conversion sequencer
`timescale 1ns/1ps
module tb
	import acsq_pkg::*;
;
	localparam logic [31:0] ST = 32'h1 << CSR_START;
	localparam logic [31:0] IE = 32'h1 << CSR_IEN;
	localparam logic [31:0] SC = 32'h1 << CSR_SCAN;
	localparam logic [31:0] FS = 32'h1 << CSR_SPD;

	logic           hclk = 1'b0;
	logic           hresetn = 1'b0;
	logic           hsel = 1'b0;
	logic [31:0]    haddr = 32'h0;
	logic [1:0]     htrans = 2'h0;
	logic           hwrite = 1'b0;
	logic [2:0]     hsize = 3'h0;
	logic [31:0]    hwdata = 32'h0;
	logic           pin_n = 1'b1;
	logic           alt = 1'b0;
	logic           hreadyout;
	logic           hresp;
	logic [31:0]    hrdata;
	logic           cmp_above;
	logic [RES-1:0] dac_code;
	logic           sample_hold;
	logic [1:0]     mux_channel;
	logic           irq;
	logic [31:0]    rv;
	logic           seen;
	int             fail_count = 0;
	int             n_checks = 0;
	int             cyc = 0;
	int             n;
	int             t1;

	always #4 hclk = ~hclk;
	always @(posedge hclk) cyc <= cyc + 1;

	acsq_top i_acsq_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .conversion_trigger_pin_n(pin_n),
		.cmp_above(cmp_above), .dac_code(dac_code),
		.sample_hold(sample_hold), .mux_channel(mux_channel),
		.conversion_end_irq(irq));
	acsq_analog_model i_acsq_analog_model (.dac_code(dac_code),
		.mux_channel(mux_channel), .alt(alt), .cmp_above(cmp_above));

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e)
		begin
			fail_count++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
		end
	endtask

	task end_sim;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic wt(input logic lvl, input int lim, output int k);
		for (k = 1; k <= lim; k++)
		begin
			@(posedge hclk);
			#1;
			if ((lim < 100 ? hreadyout : irq) === lvl)
				return;
		end
		fail_count++;
		$display("CHECK FAILED t=%0t wait ran out", $time);
		end_sim();
	endtask

	// Ready is read in the edge's own time step, before its updates land
	task automatic rdy;
		int i;
		for (i = 0; i < 50; i++)
		begin
			@(posedge hclk);
			if (hreadyout === 1'b1)
				return;
		end
		wt(1'b1, 1, i);
	endtask

	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		hsize <= HSIZE_WORD;
		rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
		q = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask

	initial
	begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		xfer(1'b0, OFS_CSR, 32'h0, rv); chk(rv, 32'h0);
		xfer(1'b0, OFS_ETC, 32'h0, rv); chk(rv, 32'h7E);
		wr(OFS_ETC, 32'h80);
		xfer(1'b0, OFS_ETC, 32'h0, rv); chk(rv, 32'hFE);
		wr(OFS_ETC, 32'h0);
		xfer(1'b0, 8'h0C, 32'h0, rv); chk(rv, 32'h0);
		$display("test registers done");
		for (int c = 0; c < NCH; c++)
		begin
			wr(OFS_CSR, IE | ST | (c[0] ? FS : 0) | c);
			wt(1'b1, 2000, n);
			chk(32'(n >= (c[0] ? 70 : 132) && n <= (c[0] ? 71 : 135)), 1);
			xfer(1'b0, OFS_DAT0 + 8'(4 * c), 0, rv);
			chk(rv, 32'({c[1:0], 8'hA5}));
			wr(OFS_CSR, IE);
			repeat (2) @(posedge hclk);
			chk(irq, 1'b1);
			xfer(1'b0, OFS_CSR, 32'h0, rv); chk(rv, 32'hC0);
			wr(OFS_CSR, IE);
			wt(1'b0, 2000, n); chk(32'(n <= 2), 1);
		end
		$display("test single done");
		wr(OFS_ETC, 32'h80);
		wr(OFS_CSR, IE | FS | 1);
		pin_n <= 1'b0;
		wt(1'b1, 2000, n);
		pin_n <= 1'b1;
		xfer(1'b0, OFS_CSR, 32'h0, rv); chk(rv, 32'hC9);
		wr(OFS_CSR, IE | FS | 1);
		wr(OFS_IEG, 32'h20);
		pin_n <= 1'b0;
		repeat (20) @(posedge hclk);
		xfer(1'b0, OFS_CSR, 32'h0, rv); chk(rv, 32'h49);
		pin_n <= 1'b1;
		wt(1'b1, 2000, n);
		xfer(1'b0, OFS_CSR, 32'h0, rv); chk(rv, 32'hC9);
		wr(OFS_CSR, FS | 1);
		wr(OFS_ETC, 32'h0);
		pin_n <= 1'b0;
		repeat (20) @(posedge hclk);
		pin_n <= 1'b1;
		repeat (20) @(posedge hclk);
		xfer(1'b0, OFS_CSR, 32'h0, rv); chk(rv, 32'h09);
		$display("test trigger done");
		alt <= 1'b1;
		wr(OFS_CSR, IE | ST | SC | FS | 2);
		wt(1'b1, 2000, n);
		t1 = cyc;
		xfer(1'b0, OFS_CSR, 32'h0, rv); chk(rv, 32'hFA);
		wr(OFS_CSR, IE | ST | SC | FS | 2);
		wt(1'b0, 2000, n);
		wt(1'b1, 2000, n);
		chk(cyc - t1, 3 * 66);
		// Stop lands inside the first conversion, clear of sampling
		repeat (40) @(posedge hclk);
		wr(OFS_CSR, SC | FS | 2);
		seen = 1'b0;
		repeat (200) @(posedge hclk) seen = seen | sample_hold;
		chk(seen, 1'b0);
		for (int c = 0; c < NCH; c++)
		begin
			xfer(1'b0, OFS_DAT0 + 8'(4 * c), 0, rv);
			chk(rv, 32'({c[1:0], 8'hA5} ^ (c < 3 ? 10'h3FF : 10'h0)));
		end
		$display("test scan done");
		end_sim();
	end
endmodule
